// ---- hw/dsp_status_flag_register.sv ----
/*
 * DSP status flag register: result flags, DSP condition flag, CPU test flag
 * forwarding and system register load/store access.
 * Assumes the pipeline presents one instruction per cycle on EXEC_VALID with
 * its kind, result and operands; the CPU owns its own status register and
 * takes the test flag when TEST_FLAG_WE pulses.
 */
// Behaviour
// [RQ1] Bits 31..12 read zero, written zero
// [RQ2] Bits 11..9 pick test flag source
// [RQ3] Saturation bit set: overflow detected for test
// [RQ4] Update enable 0 leaves test flag alone
// [RQ5] Update enable 1: DSP ops update test flag
// [RQ6] Conditional DSP ops never touch test flag
// [RQ7] Bit 7 set when result positive or greater
// [RQ8] Bit 6 set when result zero or equal
// [RQ9] Bit 5 set when result negative or less
// [RQ10] Bit 4 tracks overflow on updating ops
// [RQ11] Bits 3..1 pick condition flag source
// [RQ12] Bit 0 shows whether chosen status occurred
// [RQ13] Carry ops load carry into bit 0
// [RQ14] Four access paths: move, store, load, pop
// [RQ15] Store to general register: upper half zero
// [RQ16] Conditional DSP ops never modify register
// [RQ17] Only unconditional arithmetic ops update flags
// [RQ18] Reset clears the whole register
module dsp_status_flag_register
    import dsp_status_pkg::*;
#(
    parameter int unsigned DW = 40
)
(
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST_B,
    // Execute stage
    input  wire logic                 EXEC_VALID,
    input  wire op_kind_e             EXEC_KIND,
    input  wire logic                 EXEC_CONDITIONAL,
    input  wire logic                 EXEC_COMPARE,
    input  wire logic [DW-1:0]        EXEC_RESULT,
    input  wire logic [DW-1:0]        EXEC_OPERAND_A,
    input  wire logic [DW-1:0]        EXEC_OPERAND_B,
    input  wire logic                 EXEC_CARRY,
    input  wire logic                 EXEC_OVERFLOW,
    input  wire logic                 SATURATION_MODE,
    // System register access
    input  wire logic                 SYSREG_LOAD,
    input  wire logic                 SYSREG_LOAD_MEM,
    input  wire logic [REG_WIDTH-1:0] SYSREG_WDATA,
    input  wire logic                 SYSREG_STORE,
    input  wire logic                 SYSREG_STORE_MEM,
    output logic [REG_WIDTH-1:0]      SYSREG_RDATA,
    // State and test flag
    output logic [REG_WIDTH-1:0]      DSP_STATUS_REGISTER,
    output logic                      DSP_CONDITION_FLAG,
    output logic                      TEST_FLAG_WE,
    output logic                      TEST_FLAG
);

    // =====================================================================
    // Register fields
    // =====================================================================
    logic [2:0] test_flag_source_select_q, test_flag_source_select_d;
    logic       test_flag_update_enable_q, test_flag_update_enable_d;
    logic       signed_greater_flag_q, signed_greater_flag_d;
    logic       zero_flag_q, zero_flag_d;
    logic       negative_flag_q, negative_flag_d;
    logic       overflow_flag_q, overflow_flag_d;
    logic [2:0] condition_source_select_q, condition_source_select_d;
    logic       dsp_condition_flag_q, dsp_condition_flag_d;
    logic       test_flag_we_q, test_flag_we_d;
    logic       test_flag_q, test_flag_d;
    logic [REG_WIDTH-1:0] rdata_q, rdata_d;

    // =====================================================================
    // Flag derivation from the executing operation
    // =====================================================================
    logic new_gt;
    logic new_z;
    logic new_n;
    logic new_v;
    logic cond_status;
    logic test_status;

    result_flags #(
        .DW (DW)
    ) u_flags (
        .RESULT    (EXEC_RESULT),
        .OPERAND_A (EXEC_OPERAND_A),
        .OPERAND_B (EXEC_OPERAND_B),
        .COMPARE   (EXEC_COMPARE),
        .GREATER   (new_gt),       // [RQ7]
        .ZERO      (new_z),        // [RQ8]
        .NEG       (new_n)         // [RQ9]
    );

    // Overflow taken straight from EXEC_OVERFLOW for bit 4 and the condition flag
    assign new_v = EXEC_OVERFLOW;

    status_select u_cond_sel (
        .SEL     (condition_source_select_q), // [RQ11]
        .CARRY   (EXEC_CARRY),
        .NEG     (new_n),
        .ZERO    (new_z),
        .OVF     (new_v),
        .GREATER (new_gt),
        .STATUS  (cond_status)
    );

    status_select u_test_sel (
        .SEL     (test_flag_source_select_q), // [RQ2]
        .CARRY   (EXEC_CARRY),
        .NEG     (new_n),
        .ZERO    (new_z),
        .OVF     (new_v | SATURATION_MODE & EXEC_OVERFLOW), // [RQ3]
        .GREATER (new_gt),
        .STATUS  (test_status)
    );

    // =====================================================================
    // Operation qualification
    // =====================================================================
    logic is_dsp;
    logic flag_update;
    logic carry_op;

    always_comb begin
        // DSP kinds only; CPU ops including multiply-accumulate excluded
        is_dsp = EXEC_VALID && (EXEC_KIND == OP_DSP_ALU || EXEC_KIND == OP_ADD_CARRY ||
                 EXEC_KIND == OP_SUB_BORROW || EXEC_KIND == OP_SIGNED_MULT ||
                 EXEC_KIND == OP_DATA_MOVE);
        flag_update = is_dsp && !EXEC_CONDITIONAL &&
                      EXEC_KIND != OP_SIGNED_MULT &&
                      EXEC_KIND != OP_DATA_MOVE;              // [RQ16] [RQ17]
        carry_op = EXEC_KIND == OP_ADD_CARRY || EXEC_KIND == OP_SUB_BORROW;
    end

    // =====================================================================
    // Next-state of the register
    // =====================================================================
    logic sysreg_write;
    assign sysreg_write = SYSREG_LOAD | SYSREG_LOAD_MEM;      // [RQ14]

    always_comb begin
        test_flag_source_select_d = test_flag_source_select_q;
        test_flag_update_enable_d = test_flag_update_enable_q;
        signed_greater_flag_d     = signed_greater_flag_q;
        zero_flag_d               = zero_flag_q;
        negative_flag_d           = negative_flag_q;
        overflow_flag_d           = overflow_flag_q;
        condition_source_select_d = condition_source_select_q;
        dsp_condition_flag_d      = dsp_condition_flag_q;
        if (sysreg_write) begin
            // Software load; bits above 11 are discarded
            test_flag_source_select_d = SYSREG_WDATA[TEST_SEL_LSB +: SEL_WIDTH];  // [RQ2]
            test_flag_update_enable_d = SYSREG_WDATA[TEST_EN_BIT];
            signed_greater_flag_d     = SYSREG_WDATA[GREATER_BIT];
            zero_flag_d               = SYSREG_WDATA[Z_BIT];
            negative_flag_d           = SYSREG_WDATA[N_BIT];
            overflow_flag_d           = SYSREG_WDATA[V_BIT];
            condition_source_select_d = SYSREG_WDATA[COND_SEL_LSB +: SEL_WIDTH];  // [RQ11]
            dsp_condition_flag_d      = SYSREG_WDATA[COND_FLAG_BIT];
        end else if (flag_update) begin
            signed_greater_flag_d = new_gt;                   // [RQ7]
            zero_flag_d           = new_z;                    // [RQ8]
            negative_flag_d       = new_n;                    // [RQ9]
            overflow_flag_d       = new_v;                    // [RQ10]
            if (carry_op) begin
                dsp_condition_flag_d = EXEC_CARRY;            // [RQ13]
            end else begin
                dsp_condition_flag_d = cond_status;           // [RQ12]
            end
        end
    end

    // =====================================================================
    // Test flag forwarding to the CPU
    // =====================================================================
    always_comb begin
        // Not for conditional ops, only when enabled
        test_flag_we_d = is_dsp && !EXEC_CONDITIONAL &&
                         test_flag_update_enable_q;           // [RQ4] [RQ5] [RQ6]
        test_flag_d    = test_flag_we_d ? test_status : test_flag_q;
    end

    // =====================================================================
    // Read data for store paths
    // =====================================================================
    logic [REG_WIDTH-1:0] image;

    always_comb begin
        image = '0;                                           // [RQ1] [RQ15]
        image[TEST_SEL_LSB +: SEL_WIDTH] = test_flag_source_select_q;
        image[TEST_EN_BIT]               = test_flag_update_enable_q;
        image[GREATER_BIT]               = signed_greater_flag_q;
        image[Z_BIT]                     = zero_flag_q;
        image[N_BIT]                     = negative_flag_q;
        image[V_BIT]                     = overflow_flag_q;
        image[COND_SEL_LSB +: SEL_WIDTH] = condition_source_select_q;
        image[COND_FLAG_BIT]             = dsp_condition_flag_q;
        if (SYSREG_STORE || SYSREG_STORE_MEM) begin
            rdata_d = image;                                  // [RQ14]
        end else begin
            rdata_d = rdata_q;
        end
    end

    // =====================================================================
    // State registers
    // =====================================================================
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            // Whole register cleared
            test_flag_source_select_q <= STATUS_RESET[TEST_SEL_LSB +: SEL_WIDTH]; // [RQ18]
            test_flag_update_enable_q <= STATUS_RESET[TEST_EN_BIT];
            signed_greater_flag_q     <= STATUS_RESET[GREATER_BIT];
            zero_flag_q               <= STATUS_RESET[Z_BIT];
            negative_flag_q           <= STATUS_RESET[N_BIT];
            overflow_flag_q           <= STATUS_RESET[V_BIT];
            condition_source_select_q <= STATUS_RESET[COND_SEL_LSB +: SEL_WIDTH];
            dsp_condition_flag_q      <= STATUS_RESET[COND_FLAG_BIT];
            test_flag_we_q            <= 1'b0;
            test_flag_q               <= 1'b0;
            rdata_q                   <= '0;
        end else begin
            test_flag_source_select_q <= test_flag_source_select_d;
            test_flag_update_enable_q <= test_flag_update_enable_d;
            signed_greater_flag_q     <= signed_greater_flag_d;
            zero_flag_q               <= zero_flag_d;
            negative_flag_q           <= negative_flag_d;
            overflow_flag_q           <= overflow_flag_d;
            condition_source_select_q <= condition_source_select_d;
            dsp_condition_flag_q      <= dsp_condition_flag_d;
            test_flag_we_q            <= test_flag_we_d;
            test_flag_q               <= test_flag_d;
            rdata_q                   <= rdata_d;
        end
    end

    // Outputs
    assign SYSREG_RDATA        = rdata_q;
    assign DSP_STATUS_REGISTER = image;
    assign DSP_CONDITION_FLAG  = dsp_condition_flag_q;
    assign TEST_FLAG_WE        = test_flag_we_q;
    assign TEST_FLAG           = test_flag_q;

endmodule

// ---- hw/dsp_status_pkg.sv ----
/*
 * Package for the DSP status flag register: field positions, reset value,
 * status select encodings and operation kinds.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package dsp_status_pkg;

    // =====================================================================
    // Field layout of the DSP status register
    // =====================================================================
    localparam int unsigned REG_WIDTH      = 32;
    localparam int unsigned IMPL_MSB       = 11;
    localparam int unsigned TEST_SEL_LSB   = 9;
    localparam int unsigned TEST_EN_BIT    = 8;
    localparam int unsigned GREATER_BIT    = 7;
    localparam int unsigned Z_BIT          = 6;
    localparam int unsigned N_BIT          = 5;
    localparam int unsigned V_BIT          = 4;
    localparam int unsigned COND_SEL_LSB   = 1;
    localparam int unsigned COND_FLAG_BIT  = 0;
    localparam int unsigned SEL_WIDTH      = 3;
    localparam logic [11:0] STATUS_RESET   = 12'h000;

    // =====================================================================
    // Result status selections for DSP condition flag and CPU test flag
    // =====================================================================
    localparam logic [2:0] SEL_CARRY      = 3'h0;
    localparam logic [2:0] SEL_NEGATIVE   = 3'h1;
    localparam logic [2:0] SEL_ZERO       = 3'h2;
    localparam logic [2:0] SEL_OVERFLOW   = 3'h3;
    localparam logic [2:0] SEL_GREATER    = 3'h4;
    localparam logic [2:0] SEL_GREATER_EQ = 3'h5;

    // =====================================================================
    // Kinds of instruction presented in the execute stage
    // =====================================================================
    typedef enum logic [2:0] {
        OP_NONE,
        OP_DSP_ALU,
        OP_ADD_CARRY,
        OP_SUB_BORROW,
        OP_SIGNED_MULT,
        OP_DATA_MOVE,
        OP_CPU
    } op_kind_e;

endpackage

// ---- hw/result_flags.sv ----
/*
 * Derives greater, zero and negative flags from an operation result or from
 * an operand comparison; carry and overflow are not handled here.
 * Assumes result and operands are signed values of the datapath width.
 */
module result_flags
    import dsp_status_pkg::*;
#(
    parameter int unsigned DW = 40
)
(
    input  wire logic [DW-1:0] RESULT,
    input  wire logic [DW-1:0] OPERAND_A,
    input  wire logic [DW-1:0] OPERAND_B,
    input  wire logic          COMPARE,
    output logic               GREATER,
    output logic               ZERO,
    output logic               NEG
);

    // =====================================================================
    // Flag derivation
    // =====================================================================
    logic signed [DW-1:0] sa;
    logic signed [DW-1:0] sb;
    logic signed [DW-1:0] sres;

    assign sa   = OPERAND_A;
    assign sb   = OPERAND_B;
    assign sres = RESULT;

    always_comb begin
        if (COMPARE) begin
            GREATER = sa > sb;
            ZERO    = sa == sb;
            NEG     = sa < sb;
        end else begin
            GREATER = (sres > 0);
            ZERO    = (sres == 0);
            NEG     = sres[DW-1];
        end
    end

endmodule

// ---- hw/status_select.sv ----
/*
 * Six-way result status selector, shared by the DSP condition flag and the
 * CPU test flag paths.
 * Assumes encodings 110 and 111 are never programmed; they yield zero.
 */
module status_select
    import dsp_status_pkg::*;
(
    input  wire logic [2:0] SEL,
    input  wire logic       CARRY,
    input  wire logic       NEG,
    input  wire logic       ZERO,
    input  wire logic       OVF,
    input  wire logic       GREATER,
    output logic            STATUS
);

    // =====================================================================
    // Select mux
    // =====================================================================
    always_comb begin
        case (SEL)
            SEL_CARRY:      STATUS = CARRY;
            SEL_NEGATIVE:   STATUS = NEG;
            SEL_ZERO:       STATUS = ZERO;
            SEL_OVERFLOW:   STATUS = OVF;
            SEL_GREATER:    STATUS = GREATER;
            SEL_GREATER_EQ: STATUS = GREATER | ZERO;
            default:        STATUS = 1'b0;
        endcase
    end

endmodule

// ---- sim/cpu_side_model.sv ----
/* CPU side model: holds the CPU test flag and forms legal register words.
   Assumes the flag block pulses its write enable for one core cycle. */
module cpu_side_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic flag_we,
    input  wire logic flag,
    output logic      t_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    // CPU test flag, taken only on the write pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) t_bit <= 1'b0;
        else if (flag_we) t_bit <= flag;
    end
    // Folds a random word into a legal one: no reserved codes or bits
    function automatic logic [31:0] legal_word(input logic [31:0] x);
        logic [2:0] ts;
        logic [2:0] cs;
        ts = (x[2:0] > 3'h5) ? x[2:0] - 3'h2 : x[2:0];
        cs = (x[5:3] > 3'h5) ? x[5:3] - 3'h2 : x[5:3];
        return {20'h00000, ts, x[10:6], cs, x[11]};
    endfunction
endmodule

// ---- sim/dsp_status_flag_register_props.sv ----
/* Checker for the DSP status flag register ports.
   Assumes one core clock and an asynchronous active low reset. */
module dsp_status_flag_register_props
    import dsp_status_pkg::*;
#(
    parameter int unsigned DW = 40
)
(
    input wire logic          CORE_CLK,
    input wire logic          RST_B,
    input wire logic          EXEC_VALID,
    input wire op_kind_e      EXEC_KIND,
    input wire logic          EXEC_CONDITIONAL,
    input wire logic          EXEC_COMPARE,
    input wire logic [DW-1:0] EXEC_RESULT,
    input wire logic          EXEC_CARRY,
    input wire logic          SYSREG_LOAD,
    input wire logic          SYSREG_LOAD_MEM,
    input wire logic [31:0]   SYSREG_WDATA,
    input wire logic          SYSREG_STORE,
    input wire logic [31:0]   SYSREG_RDATA,
    input wire logic [31:0]   DSP_STATUS_REGISTER,
    input wire logic          DSP_CONDITION_FLAG,
    input wire logic          TEST_FLAG_WE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    // Load strobe and flag update qualifiers
    logic ld;
    logic upd;
    assign ld = SYSREG_LOAD | SYSREG_LOAD_MEM;
    assign upd = EXEC_VALID & ~EXEC_CONDITIONAL & ~ld;
    upper_zero_a: assert property (DSP_STATUS_REGISTER[31:12] == 20'h00000)
        else $error("reserved bits not zero");
    rdata_upper_a: assert property (SYSREG_RDATA[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    tflag_off_a: assert property (
        (!EXEC_VALID || !DSP_STATUS_REGISTER[8] || EXEC_CONDITIONAL) |=> !TEST_FLAG_WE)
        else $error("test flag written while disabled");
    tflag_on_a: assert property (
        upd && DSP_STATUS_REGISTER[8] &&
        EXEC_KIND inside {[OP_DSP_ALU:OP_DATA_MOVE]} |=> TEST_FLAG_WE)
        else $error("test flag not written");
    cond_keep_a: assert property (
        EXEC_VALID && EXEC_CONDITIONAL && !ld |=> $stable(DSP_STATUS_REGISTER))
        else $error("conditional op changed register");
    cpu_cond_keep_a: assert property (
        EXEC_VALID && EXEC_KIND == OP_CPU && !ld |=> $stable(DSP_CONDITION_FLAG))
        else $error("cpu op changed condition flag");
    carry_cond_a: assert property (
        upd && EXEC_KIND inside {OP_ADD_CARRY, OP_SUB_BORROW}
        |=> DSP_CONDITION_FLAG == $past(EXEC_CARRY))
        else $error("condition flag not carry");
    zero_flag_a: assert property (
        upd && EXEC_KIND == OP_DSP_ALU && !EXEC_COMPARE
        |=> DSP_STATUS_REGISTER[6] == ($past(EXEC_RESULT) == '0))
        else $error("zero flag wrong");
    load_write_a: assert property (
        ld |=> DSP_STATUS_REGISTER[11:0] == $past(SYSREG_WDATA[11:0]))
        else $error("load not taken");
    store_read_a: assert property (
        SYSREG_STORE && !ld |=> SYSREG_RDATA == $past(DSP_STATUS_REGISTER))
        else $error("store data wrong");
    cond_zero_a: assert property (
        upd && EXEC_KIND == OP_DSP_ALU && !EXEC_COMPARE && DSP_STATUS_REGISTER[3:1] == 3'h2
        |=> DSP_CONDITION_FLAG == ($past(EXEC_RESULT) == '0))
        else $error("condition flag not zero status");
endmodule

bind dsp_status_flag_register dsp_status_flag_register_props #(.DW(DW)) u_props (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .EXEC_VALID(EXEC_VALID), .EXEC_KIND(EXEC_KIND),
    .EXEC_CONDITIONAL(EXEC_CONDITIONAL), .EXEC_COMPARE(EXEC_COMPARE),
    .EXEC_RESULT(EXEC_RESULT), .EXEC_CARRY(EXEC_CARRY), .SYSREG_LOAD(SYSREG_LOAD),
    .SYSREG_LOAD_MEM(SYSREG_LOAD_MEM), .SYSREG_WDATA(SYSREG_WDATA),
    .SYSREG_STORE(SYSREG_STORE), .SYSREG_RDATA(SYSREG_RDATA),
    .DSP_STATUS_REGISTER(DSP_STATUS_REGISTER), .DSP_CONDITION_FLAG(DSP_CONDITION_FLAG),
    .TEST_FLAG_WE(TEST_FLAG_WE)
);

// ---- sim/test_dsp_status_flag_register.sv ----
/* Self-checking bench for the DSP status flag register.
   Assumes the package, the design files and the CPU side model. */
module test_dsp_status_flag_register
    import dsp_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          core_clk, rst_b, exec_valid, exec_conditional, exec_compare;
    logic          exec_carry, exec_overflow, saturation_mode, t_bit, exp_t, t_ok;
    logic          sysreg_load, sysreg_load_mem, sysreg_store, sysreg_store_mem;
    logic          dsp_condition_flag, test_flag_we, test_flag;
    op_kind_e      exec_kind;
    logic [39:0]   exec_result, operand_a, operand_b, r, a, b;
    logic [31:0]   sysreg_wdata, sysreg_rdata, dsp_status_register;
    logic [11:0]   exp_q;
    int            num_errors, compares, seed;

    dsp_status_flag_register #(.DW(40)) u_dsp_status_flag_register (
        .CORE_CLK(core_clk), .RST_B(rst_b), .EXEC_VALID(exec_valid), .EXEC_KIND(exec_kind),
        .EXEC_CONDITIONAL(exec_conditional), .EXEC_COMPARE(exec_compare),
        .EXEC_RESULT(exec_result), .EXEC_OPERAND_A(operand_a), .EXEC_OPERAND_B(operand_b),
        .EXEC_CARRY(exec_carry), .EXEC_OVERFLOW(exec_overflow),
        .SATURATION_MODE(saturation_mode), .SYSREG_LOAD(sysreg_load),
        .SYSREG_LOAD_MEM(sysreg_load_mem), .SYSREG_WDATA(sysreg_wdata),
        .SYSREG_STORE(sysreg_store), .SYSREG_STORE_MEM(sysreg_store_mem),
        .SYSREG_RDATA(sysreg_rdata), .DSP_STATUS_REGISTER(dsp_status_register),
        .DSP_CONDITION_FLAG(dsp_condition_flag), .TEST_FLAG_WE(test_flag_we),
        .TEST_FLAG(test_flag)
    );
    cpu_side_model u_cpu_side_model (
        .clk(core_clk), .rst_b(rst_b), .flag_we(test_flag_we), .flag(test_flag), .t_bit(t_bit)
    );

    // ======================================================================
    // Expectation functions and compare tasks
    // ======================================================================
    function automatic logic [2:0] flags3(input logic c, input logic signed [39:0] x, p, q);
        if (c) return {p > q, p == q, p < q};
        return {x > 0, x == 0, x[39]};
    endfunction
    function automatic logic pick(input logic [2:0] s, input logic c, n, z, v, g);
        case (s)
            3'h0: return c;
            3'h1: return n;
            3'h2: return z;
            3'h3: return v;
            3'h4: return g;
            3'h5: return g | z;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ======================================================================
    // Bus tasks, driven at the falling edge
    // ======================================================================
    task automatic reg_load(input logic [31:0] w, input logic mem);
        @(negedge core_clk);
        sysreg_wdata = w;
        sysreg_load = !mem;
        sysreg_load_mem = mem;
        @(negedge core_clk);
        sysreg_load = 1'b0;
        sysreg_load_mem = 1'b0;
        exp_q = w[11:0];
        chk_word(dsp_status_register, w);
    endtask
    task automatic reg_store(input logic mem);
        @(negedge core_clk);
        sysreg_store = !mem;
        sysreg_store_mem = mem;
        @(negedge core_clk);
        sysreg_store = 1'b0;
        sysreg_store_mem = 1'b0;
        chk_word(sysreg_rdata, {20'h00000, exp_q});
    endtask
    // One op; m holds conditional, compare, saturation, carry, overflow
    task automatic exec(input op_kind_e k, input logic [5:0] m, input logic [39:0] x, p, q);
        logic [2:0] f;
        logic       cnd;
        logic       st;
        logic       we;
        logic       upd;
        cnd = m[0] & m[1];
        @(negedge core_clk);
        if (t_ok) chk_bit(t_bit, exp_t);
        exec_valid = 1'b1;
        exec_kind = k;
        exec_conditional = cnd;
        exec_compare = m[2];
        saturation_mode = m[3];
        exec_carry = m[4];
        exec_overflow = m[5];
        exec_result = x;
        operand_a = p;
        operand_b = q;
        f = flags3(m[2], x, p, q);
        upd = !cnd && k inside {OP_DSP_ALU, OP_ADD_CARRY, OP_SUB_BORROW};
        we = !cnd && exp_q[8] && k inside {[OP_DSP_ALU:OP_DATA_MOVE]};
        st = pick(exp_q[11:9], m[4], f[0], f[1], m[5], f[2]);
        if (upd && k == OP_DSP_ALU) exp_q[0] = pick(exp_q[3:1], m[4], f[0], f[1], m[5], f[2]);
        if (upd && k != OP_DSP_ALU) exp_q[0] = m[4];
        if (upd) exp_q[7:4] = {f, m[5]};
        @(negedge core_clk);
        exec_valid = 1'b0;
        chk_word(dsp_status_register, {20'h0, exp_q});
        chk_bit(dsp_condition_flag, exp_q[0]);
        chk_bit(test_flag_we, we);
        if (we) chk_bit(test_flag, st);
        if (we) t_ok = upd;
        if (we) exp_t = st;
    endtask

    // Core clock, 25 ns period
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Watchdog against a hung run
    initial begin
        #1000000;
        num_errors++;
        complete_run();
    end
    // Main sequence: reset, select codes, random traffic, second reset
    initial begin
        {rst_b, exec_valid, exec_conditional, exec_compare, exec_carry} = '0;
        {exec_overflow, saturation_mode, sysreg_load, sysreg_load_mem} = '0;
        {sysreg_store, sysreg_store_mem, exec_result, operand_a, operand_b, sysreg_wdata} = '0;
        exec_kind = OP_NONE;
        {exp_q, exp_t, num_errors, compares} = '0;
        t_ok = 1'b1;
        seed = 88664;
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        chk_word(dsp_status_register, 32'h00000000);
        for (int s = 0; s < 6; s++) begin
            reg_load({20'h00000, 3'(s), 5'h10, 3'(s), 1'b0}, 1'(s));
            exec(OP_DSP_ALU, 6'h3c, 40'h0, 40'h1, 40'h2);
            reg_store(1'(s));
        end
        for (int i = 0; i < 300; i++) begin
            if (i % 8 == 0) reg_load(u_cpu_side_model.legal_word($random(seed)), 1'(i / 8));
            r = (i % 5 == 0) ? 40'h0 : 40'({$random(seed), $random(seed)});
            a = 40'({$random(seed), $random(seed)});
            b = (i % 6 == 0) ? a : 40'({$random(seed), $random(seed)});
            exec(op_kind_e'(($random(seed) & 32'hff) % 7), 6'($random(seed)), r, a, b);
            if (i % 16 == 0) reg_store(1'(i / 16));
        end
        @(negedge core_clk);
        rst_b = 1'b0;
        @(negedge core_clk);
        chk_word(dsp_status_register, 32'h00000000);
        chk_word(sysreg_rdata, 32'h00000000);
        chk_bit(test_flag_we, 1'b0);
        chk_bit(test_flag, 1'b0);
        // Release again and prove the block works from a clean state
        rst_b = 1'b1;
        {exp_q, exp_t} = '0;
        exec(OP_DSP_ALU, 6'h00, 40'h0, 40'h0, 40'h0);
        reg_store(1'b0);
        complete_run();
    end
endmodule
